// *** hw/exc_pkg.sv ***
// Constants for the critical, machine check and data storage exception unit.
// Assumes a 32-bit core that presents retire-stage events on pclk.
package exc_pkg;
   // Machine state word bit positions (bit 0 is the least significant here).
   localparam int MSW_WAIT  = 18;
   localparam int MSW_CRIT  = 17;
   localparam int MSW_EXT   = 15;
   localparam int MSW_USER  = 14;
   localparam int MSW_FPU   = 13;
   localparam int MSW_MCHK  = 12;
   localparam int MSW_FPX0  = 11;
   localparam int MSW_DWAIT = 10;
   localparam int MSW_DBG   = 9;
   localparam int MSW_FPX1  = 8;
   localparam int MSW_IXL   = 5;
   localparam int MSW_DXL   = 4;
   localparam int MSW_APU   = 25;
   localparam int MSW_APUX  = 19;
   // Syndrome bit positions.
   localparam int SYN_FMCHK = 31;
   localparam int SYN_STORE = 23;
   localparam int SYN_ZONE  = 22;
   localparam int SYN_UATTR = 15;
   localparam int CFG_UATTR = 0;
   // Vector offsets.
   localparam logic [15:0] VEC_CRIT = 16'h0100;
   localparam logic [15:0] VEC_MCHK = 16'h0200;
   localparam logic [15:0] VEC_DSI  = 16'h0300;
   localparam logic [15:0] PFX_MASK = 16'hFFFF;
   // Zone field codes.
   localparam logic [1:0] ZONE_NONE = 2'h0;
   localparam logic [1:0] ZONE_SUP  = 2'h2;
   localparam logic [1:0] ZONE_ALL  = 2'h3;
   // Cache line geometry.
   localparam int LINE_WORDS = 8;
   localparam int LINE_AW    = 3;
   localparam int NUM_LINES  = 16;
   localparam int IDX_W      = 4;
   // Register byte addresses on APB.
   localparam logic [7:0] A_MSW   = 8'h00;
   localparam logic [7:0] A_SPC0  = 8'h04;
   localparam logic [7:0] A_SST0  = 8'h08;
   localparam logic [7:0] A_SPC2  = 8'h0C;
   localparam logic [7:0] A_SST2  = 8'h10;
   localparam logic [7:0] A_VPFX  = 8'h14;
   localparam logic [7:0] A_SYN   = 8'h18;
   localparam logic [7:0] A_FDAR  = 8'h1C;
   localparam logic [7:0] A_CFG   = 8'h20;
   localparam logic [7:0] A_PC    = 8'h24;
   localparam logic [7:0] A_LINEV = 8'h28;
   localparam logic [31:0] MSW_RST = 32'h0000_0000;
   localparam logic [31:0] ZERO32  = 32'h0000_0000;
   // Data access kinds.
   typedef enum logic [2:0] {
      OP_LOAD = 3'h0, OP_STORE = 3'h1, OP_LZERO = 3'h2, OP_LINV = 3'h3,
      OP_CINV = 3'h4, OP_TOUCH = 3'h5, OP_ICOP = 3'h6, OP_FLUSH = 3'h7
   } op_t;
endpackage

// *** hw/line_valid_mem.sv ***
// Small valid/error store for instruction cache lines.
// Assumes one write port and one registered read port on pclk.
`timescale 1ns/100ps
`default_nettype none
module line_valid_mem (
   // Clock and reset
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   // Write port
   input  wire logic                    wr_en,
   input  wire logic [exc_pkg::IDX_W-1:0] wr_idx,
   input  wire logic                    wr_val,
   // Read port
   input  wire logic [exc_pkg::IDX_W-1:0] rd_idx,
   output logic                         rd_val
);
   logic [exc_pkg::NUM_LINES-1:0] valid_r;

   genvar g;
   generate
      for (g = 0; g < exc_pkg::NUM_LINES; g++) begin : g_line
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               valid_r[g] <= 1'b0;
            end else if (wr_en && wr_idx == exc_pkg::IDX_W'(g)) begin
               valid_r[g] <= wr_val;
            end
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_val <= 1'b0;
      end else begin
         rd_val <= valid_r[rd_idx];
      end
   end
endmodule // line_valid_mem
`default_nettype wire

// *** hw/exc_unit.sv ***
// Exception unit: critical input, machine checks and data storage interrupt.
// Assumes the pipeline presents one retiring instruction per cycle on pclk.
// Notes on behaviour
// RULE_01: Critical input honoured only when critical enable set.
// RULE_02: Critical taken at once, saves next pc, state; the code defers it while sync_pending is set.
// RULE_03: Critical entry clears all state except mcheck enable.
// RULE_04: Critical vector is prefix with 0x0100.
// RULE_05: Critical return restores pc and state.
// RULE_06: Fetch machine check raised only at execution.
// RULE_07: Data bus error raises data machine check.
// RULE_08: Mcheck saves excepting or next pc, state.
// RULE_09: Mcheck clears listed fields, vectors to 0x0200.
// RULE_10: Fetch mcheck flag set even when disabled.
// RULE_11: Re-enabling does not fire on old flag.
// RULE_12: Taken fetch mcheck sets flag, clears others.
// RULE_13: Line with bad word invalidated after fill.
// RULE_14: Store to user attribute faults when enabled.
// RULE_15: User zone 00 faults; touches become no-ops.
// RULE_16: User store to read-only page faults.
// RULE_17: Supervisor store-like faults unless zone 11/10.
// RULE_18: Instruction cache ops checked as loads.
// RULE_19: Data fault saves pc, address, state; 0x0300.
// RULE_20: Data fault keeps crit, mcheck, debug enables.
// RULE_21: Data fault syndrome bits set, fetch flag kept.
// RULE_22: Privileged program fault beats data fault.
// RULE_23: Vector is prefix high half with offset.
`timescale 1ns/100ps
`default_nettype none
module exc_unit (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Critical input pin
   input  wire logic        crit_irq_pin,
   // Retiring instruction
   input  wire logic        ret_valid,
   input  wire logic [31:0] ret_pc,
   input  wire logic [31:0] ret_next_pc,
   input  wire logic        ret_fetch_err,
   input  wire logic        ret_crit_return,
   input  wire logic        ret_prog_priv,
   input  wire logic        sync_pending,
   // Data access of retiring instruction
   input  wire logic        dacc_valid,
   input  wire exc_pkg::op_t dacc_op,
   input  wire logic [31:0] dacc_addr,
   input  wire logic [1:0]  dacc_zone,
   input  wire logic        dacc_store_permit,
   input  wire logic        dacc_user_attr,
   input  wire logic        dacc_bus_err,
   // Instruction line fill
   input  wire logic        fill_valid,
   input  wire logic [exc_pkg::IDX_W-1:0] fill_idx,
   input  wire logic        fill_err,
   input  wire logic [exc_pkg::IDX_W-1:0] look_idx,
   output logic             look_valid,
   // Pipeline control
   output logic             redirect,
   output logic [31:0]      redirect_pc,
   output logic             suppress,
   output logic             touch_nop
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [31:0] msw_r, spc0_r, sst0_r, spc2_r, sst2_r, vpfx_r, syn_r, fdar_r, cfg_r, pc_r;
   logic        crit_s1_r, crit_s2_r;
   logic [exc_pkg::LINE_AW-1:0] fill_cnt_r;
   logic        fill_bad_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crit_s1_r <= 1'b0;
         crit_s2_r <= 1'b0;
      end else begin
         crit_s1_r <= crit_irq_pin;
         crit_s2_r <= crit_s1_r;
      end
   end

   // ----------------------------------------------------------------
   // Event decode
   // ----------------------------------------------------------------
   wire user_w   = msw_r[exc_pkg::MSW_USER];
   wire dxlat_w  = msw_r[exc_pkg::MSW_DXL];
   wire mchk_en_w = msw_r[exc_pkg::MSW_MCHK];
   wire is_st_w  = (dacc_op == exc_pkg::OP_STORE) || (dacc_op == exc_pkg::OP_LZERO) ||
                   (dacc_op == exc_pkg::OP_LINV) || (dacc_op == exc_pkg::OP_CINV);
   wire is_touch = dacc_op == exc_pkg::OP_TOUCH;
   // Instruction cache ops fall through as loads under data translation.
   wire u0_flt   = dacc_valid && (dacc_op == exc_pkg::OP_STORE) && dacc_user_attr &&
                   cfg_r[exc_pkg::CFG_UATTR]; // RULE_14
   wire zone_hit = dacc_valid && user_w && dxlat_w && dacc_zone == exc_pkg::ZONE_NONE; // RULE_18
   wire zone_flt = zone_hit && !is_touch; // RULE_15
   wire usr_wflt = dacc_valid && user_w && dxlat_w && !dacc_store_permit &&
                   ((dacc_op == exc_pkg::OP_STORE) || (dacc_op == exc_pkg::OP_LZERO)) &&
                   dacc_zone != exc_pkg::ZONE_ALL; // RULE_16
   wire sup_wflt = dacc_valid && !user_w && dxlat_w && !dacc_store_permit && is_st_w &&
                   dacc_zone != exc_pkg::ZONE_ALL && dacc_zone != exc_pkg::ZONE_SUP; // RULE_17
   wire dsi_any  = ret_valid && !ret_prog_priv && (u0_flt || zone_flt || usr_wflt || sup_wflt); // RULE_22
   wire imc_ev   = ret_valid && ret_fetch_err; // RULE_06
   wire imc_take = imc_ev && mchk_en_w;
   wire dmc_take = ret_valid && dacc_valid && dacc_bus_err && mchk_en_w && !imc_ev; // RULE_07
   wire crit_take = crit_s2_r && msw_r[exc_pkg::MSW_CRIT] && !sync_pending && !imc_take &&
                    !dmc_take && !dsi_any; // RULE_01 RULE_02
   wire rfci_take = ret_valid && ret_crit_return && !imc_take && !crit_take;
   wire mc_take   = imc_take || dmc_take;

   // Clearing and keep masks for entry into each handler.
   wire [31:0] clr_nc = (32'h1 << exc_pkg::MSW_APU) | (32'h1 << exc_pkg::MSW_APUX) |
                        (32'h1 << exc_pkg::MSW_WAIT) | (32'h1 << exc_pkg::MSW_EXT) |
                        (32'h1 << exc_pkg::MSW_USER) | (32'h1 << exc_pkg::MSW_FPU) |
                        (32'h1 << exc_pkg::MSW_FPX0) | (32'h1 << exc_pkg::MSW_DWAIT) |
                        (32'h1 << exc_pkg::MSW_FPX1) | (32'h1 << exc_pkg::MSW_IXL) |
                        (32'h1 << exc_pkg::MSW_DXL);
   wire [31:0] crit_keep = 32'h1 << exc_pkg::MSW_MCHK;
   wire [31:0] mc_clr  = clr_nc | (32'h1 << exc_pkg::MSW_CRIT) | (32'h1 << exc_pkg::MSW_MCHK) |
                         (32'h1 << exc_pkg::MSW_DBG);
   wire [31:0] vbase   = {vpfx_r[31:16] & exc_pkg::PFX_MASK, 16'h0000}; // RULE_23

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   wire acc_w = psel && penable;
   wire wr_w  = acc_w && pwrite;
   wire hit_w = (paddr <= exc_pkg::A_LINEV) && (paddr[1:0] == 2'h0);
   logic [31:0] rd_mux;
   assign rd_mux = (paddr == exc_pkg::A_MSW)  ? msw_r  :
                   (paddr == exc_pkg::A_SPC0) ? spc0_r :
                   (paddr == exc_pkg::A_SST0) ? sst0_r :
                   (paddr == exc_pkg::A_SPC2) ? spc2_r :
                   (paddr == exc_pkg::A_SST2) ? sst2_r :
                   (paddr == exc_pkg::A_VPFX) ? vpfx_r :
                   (paddr == exc_pkg::A_SYN)  ? syn_r  :
                   (paddr == exc_pkg::A_FDAR) ? fdar_r :
                   (paddr == exc_pkg::A_CFG)  ? cfg_r  :
                   (paddr == exc_pkg::A_PC)   ? pc_r   :
                   (paddr == exc_pkg::A_LINEV) ? {31'h0, look_valid} : exc_pkg::ZERO32;
   assign pready  = 1'b1;
   assign pslverr = acc_w && !hit_w;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= exc_pkg::ZERO32;
      end else if (psel && !penable && !pwrite) begin
         prdata <= rd_mux;
      end
   end

   // ----------------------------------------------------------------
   // Architected state update
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         msw_r <= exc_pkg::MSW_RST;
         spc0_r <= exc_pkg::ZERO32;
         sst0_r <= exc_pkg::ZERO32;
         spc2_r <= exc_pkg::ZERO32;
         sst2_r <= exc_pkg::ZERO32;
         vpfx_r <= exc_pkg::ZERO32;
         fdar_r <= exc_pkg::ZERO32;
         cfg_r  <= exc_pkg::ZERO32;
         pc_r   <= exc_pkg::ZERO32;
      end else begin
         if (wr_w && paddr == exc_pkg::A_SPC0) spc0_r <= pwdata;
         if (wr_w && paddr == exc_pkg::A_SST0) sst0_r <= pwdata;
         if (wr_w && paddr == exc_pkg::A_SPC2) spc2_r <= pwdata;
         if (wr_w && paddr == exc_pkg::A_SST2) sst2_r <= pwdata;
         if (wr_w && paddr == exc_pkg::A_VPFX) vpfx_r <= {pwdata[31:16], 16'h0000};
         if (wr_w && paddr == exc_pkg::A_FDAR) fdar_r <= pwdata;
         if (wr_w && paddr == exc_pkg::A_CFG)  cfg_r  <= pwdata;
         if (wr_w && paddr == exc_pkg::A_MSW)  msw_r  <= pwdata; // RULE_11
         if (mc_take) begin
            spc2_r <= imc_take ? ret_pc : ret_next_pc; // RULE_08
            sst2_r <= msw_r;
            msw_r  <= msw_r & ~mc_clr; // RULE_09
            pc_r   <= vbase | {16'h0000, exc_pkg::VEC_MCHK};
         end else if (dsi_any) begin
            spc0_r <= ret_pc; // RULE_19
            sst0_r <= msw_r;
            fdar_r <= dacc_addr;
            msw_r  <= msw_r & ~clr_nc; // RULE_20
            pc_r   <= vbase | {16'h0000, exc_pkg::VEC_DSI};
         end else if (crit_take) begin
            // With nothing retiring, the next instruction is the one at the current pc.
            spc2_r <= ret_valid ? ret_next_pc : pc_r; // RULE_02
            sst2_r <= msw_r;
            msw_r  <= msw_r & crit_keep; // RULE_03
            pc_r   <= vbase | {16'h0000, exc_pkg::VEC_CRIT}; // RULE_04
         end else if (rfci_take) begin
            pc_r  <= spc2_r; // RULE_05
            msw_r <= sst2_r;
         end else if (ret_valid) begin
            pc_r <= ret_next_pc;
         end
      end
   end

   // Syndrome: hardware events win over a software write in the same cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         syn_r <= exc_pkg::ZERO32;
      end else if (imc_take) begin
         syn_r <= 32'h1 << exc_pkg::SYN_FMCHK; // RULE_12
      end else if (dsi_any) begin
         syn_r <= ({31'h0, imc_ev | syn_r[exc_pkg::SYN_FMCHK]} << exc_pkg::SYN_FMCHK) |
                  ({31'h0, is_st_w} << exc_pkg::SYN_STORE) |
                  ({31'h0, zone_flt} << exc_pkg::SYN_ZONE) |
                  ({31'h0, u0_flt} << exc_pkg::SYN_UATTR); // RULE_21
      end else if (imc_ev) begin
         syn_r[exc_pkg::SYN_FMCHK] <= 1'b1; // RULE_10
      end else if (wr_w && paddr == exc_pkg::A_SYN) begin
         syn_r <= pwdata;
      end
   end

   // ----------------------------------------------------------------
   // Line fill tracking
   // ----------------------------------------------------------------
   wire fill_last = fill_valid && fill_cnt_r == exc_pkg::LINE_AW'(exc_pkg::LINE_WORDS - 1);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fill_cnt_r <= '0;
         fill_bad_r <= 1'b0;
      end else if (fill_valid) begin
         fill_cnt_r <= fill_cnt_r + 3'h1;
         fill_bad_r <= fill_last ? 1'b0 : (fill_bad_r | fill_err);
      end
   end

   line_valid_mem u_lines (
      .pclk    (pclk),
      .presetn (presetn),
      .wr_en   (fill_last),
      .wr_idx  (fill_idx),
      .wr_val  (!(fill_bad_r || fill_err)), // RULE_13
      .rd_idx  (look_idx),
      .rd_val  (look_valid)
   );

   // ----------------------------------------------------------------
   // Pipeline outputs
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         redirect    <= 1'b0;
         redirect_pc <= exc_pkg::ZERO32;
         suppress    <= 1'b0;
         touch_nop   <= 1'b0;
      end else begin
         redirect    <= mc_take || dsi_any || crit_take || rfci_take;
         redirect_pc <= mc_take ? (vbase | {16'h0000, exc_pkg::VEC_MCHK}) :
                        dsi_any ? (vbase | {16'h0000, exc_pkg::VEC_DSI}) :
                        crit_take ? (vbase | {16'h0000, exc_pkg::VEC_CRIT}) : spc2_r;
         suppress    <= dsi_any || imc_take;
         touch_nop   <= ret_valid && zone_hit && is_touch; // RULE_15
      end
   end
endmodule // exc_unit
`default_nettype wire

// *** verification/exc_unit_asserts.sv ***
// Port-level assertions for the exception unit.
// Assumes binding to exc_unit with pclk and presetn as its only domain.
`timescale 1ns/100ps
`default_nettype none
module exc_unit_asserts (
   // Clock and reset
   input wire logic          pclk,
   input wire logic          presetn,
   // Critical input and retiring instruction
   input wire logic          crit_irq_pin,
   input wire logic          ret_valid,
   input wire logic          ret_fetch_err,
   input wire logic          ret_crit_return,
   input wire logic          ret_prog_priv,
   input wire logic          dacc_valid,
   input wire exc_pkg::op_t  dacc_op,
   input wire logic [1:0]    dacc_zone,
   input wire logic          dacc_user_attr,
   // Line fill and pipeline control
   input wire logic          fill_valid,
   input wire logic [3:0]    look_idx,
   input wire logic          look_valid,
   input wire logic          redirect,
   input wire logic [31:0]   redirect_pc,
   input wire logic          suppress,
   input wire logic          touch_nop
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_redir_cause;
      redirect |-> $past(ret_valid) || $past(crit_irq_pin, 2);
   endproperty
   a_redir_cause: assert property (p_redir_cause) else $error("redirect without retire");
   property p_dsi_vec;
      suppress |-> redirect && (redirect_pc[15:0] == 16'h0300 || redirect_pc[15:0] == 16'h0200);
   endproperty
   a_dsi_vec: assert property (p_dsi_vec) else $error("suppress without data fault vector");
   property p_touch;
      touch_nop |-> $past(dacc_valid && dacc_op == exc_pkg::OP_TOUCH && dacc_zone == 2'h0) && !suppress;
   endproperty
   a_touch: assert property (p_touch) else $error("touch no-op for wrong access");
   property p_zone_all;
      ret_valid && dacc_valid && dacc_zone == 2'h3 && !dacc_user_attr |=> !suppress;
   endproperty
   a_zone_all: assert property (p_zone_all) else $error("fault in zone with full access");
   property p_prog;
      ret_valid && ret_prog_priv |=> !suppress;
   endproperty
   a_prog: assert property (p_prog) else $error("data fault taken over program fault");
   property p_quiet;
      ret_valid && !ret_fetch_err && !ret_crit_return && !dacc_valid && !crit_irq_pin
         && !$past(crit_irq_pin) && !$past(crit_irq_pin, 2) && !$past(crit_irq_pin, 3) |=> !redirect;
   endproperty
   a_quiet: assert property (p_quiet) else $error("redirect on clean retire");
   property p_line_hold;
      !fill_valid && !$past(fill_valid) && $stable(look_idx) |=> $stable(look_valid);
   endproperty
   a_line_hold: assert property (p_line_hold) else $error("line valid changed without fill");
   property p_one_shot;
      redirect && !$past(ret_valid, 2) |=> !redirect [*2];
   endproperty
   a_one_shot: assert property (p_one_shot) else $error("redirect held too long");
endmodule // exc_unit_asserts
bind exc_unit exc_unit_asserts u_exc_unit_asserts (.pclk, .presetn, .crit_irq_pin, .ret_valid, .ret_fetch_err,
   .ret_crit_return, .ret_prog_priv, .dacc_valid, .dacc_op, .dacc_zone, .dacc_user_attr, .fill_valid, .look_idx,
   .look_valid, .redirect, .redirect_pc, .suppress, .touch_nop);
`default_nettype wire

// *** verification/crit_src_model.sv ***
// Model of the critical interrupt source and the bus error reporter.
// Assumes the bench commands it; the source moves on the falling edge.
`timescale 1ns/100ps
`default_nettype none
module crit_src_model (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Commands
   input  wire logic raise,
   input  wire logic fail,
   // Toward the core
   output logic      crit_irq_pin,
   output logic      bus_err
);
   // The source is clocked on the falling edge of pclk, so it changes level mid-cycle.
   always_ff @(negedge pclk or negedge presetn) begin
      if (!presetn) crit_irq_pin <= 1'b0;
      else crit_irq_pin <= raise;
   end
   assign bus_err = fail & presetn;
endmodule // crit_src_model
`default_nettype wire

// *** verification/critical_mcheck_dsi_handler_test.sv ***
// Self-checking bench for the exception unit.
// Assumes exc_pkg, the partner model and the checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e, m) begin samples_checked++; if ((a) !== (e)) begin bad_count++; $display("[FAIL] %0t %s", $time, m); end end
module critical_mcheck_dsi_handler_test;
   logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0]   paddr;
   logic [31:0]  pwdata, prdata, ret_pc, ret_next_pc, dacc_addr, redirect_pc, rd, got_pc;
   logic         crit_irq_pin, ret_valid, ret_fetch_err, ret_crit_return, ret_prog_priv, sync_pending;
   logic         dacc_valid, dacc_store_permit, dacc_user_attr, bus_err, raise, fail, fill_valid;
   logic [1:0]   dacc_zone;
   logic [3:0]   fill_idx, look_idx;
   logic         look_valid, redirect, suppress, touch_nop, got_r, got_s, got_t;
   exc_pkg::op_t dacc_op;
   int           bad_count, samples_checked;
   exc_unit u_exc_unit (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .crit_irq_pin, .ret_valid, .ret_pc, .ret_next_pc, .ret_fetch_err, .ret_crit_return, .ret_prog_priv,
      .sync_pending, .dacc_valid, .dacc_op, .dacc_addr, .dacc_zone, .dacc_store_permit, .dacc_user_attr,
      .dacc_bus_err(bus_err), .fill_valid, .fill_idx, .fill_err(bus_err), .look_idx, .look_valid, .redirect,
      .redirect_pc, .suppress, .touch_nop);
   crit_src_model u_crit_src_model (.pclk, .presetn, .raise, .fail, .crit_irq_pin, .bus_err);
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rd, e, "register read")
   endtask
   task automatic retire(input logic [31:0] pc, input logic fe, cr, pg, dv, input exc_pkg::op_t op,
                         input logic [1:0] z, input logic sp, ua, be);
      @(posedge pclk);
      ret_valid <= 1'b1; ret_pc <= pc; ret_next_pc <= pc + 32'h4; ret_fetch_err <= fe; ret_crit_return <= cr;
      ret_prog_priv <= pg; dacc_valid <= dv; dacc_op <= op; dacc_addr <= pc + 32'h1000; dacc_zone <= z;
      dacc_store_permit <= sp; dacc_user_attr <= ua; fail <= be;
      @(posedge pclk);
      ret_valid <= 1'b0; ret_fetch_err <= 1'b0; ret_crit_return <= 1'b0; ret_prog_priv <= 1'b0;
      dacc_valid <= 1'b0; fail <= 1'b0;
      #1;
      got_r = redirect; got_pc = redirect_pc; got_s = suppress; got_t = touch_nop;
   endtask
   task automatic dsi(input exc_pkg::op_t op, input logic [1:0] z, input logic sp, ua, usr, pg, f,
                      input logic [31:0] syn);
      logic [31:0] m;
      m = usr ? 32'h0002_D210 : 32'h0002_9210;
      apb(1'b1, 8'h18, 32'h8000_0000);
      apb(1'b1, 8'h00, m);
      retire(32'h400, 1'b0, 1'b0, pg, 1'b1, op, z, sp, ua, 1'b0);
      `CHK(got_s, f, "suppress")
      `CHK(got_t, op == exc_pkg::OP_TOUCH, "touch no-op")
      rchk(8'h18, syn);
      if (f) begin
         `CHK(got_pc, 32'hABCD_0300, "data fault vector")
         rchk(8'h04, 32'h400);
         rchk(8'h1C, 32'h1400);
         rchk(8'h08, m);
         rchk(8'h00, m & 32'h0002_1200);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   initial begin
      repeat (20000) @(posedge pclk);
      bad_count++;
      give_verdict;
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, ret_valid, ret_pc, ret_next_pc, ret_fetch_err} = '0;
      {ret_crit_return, ret_prog_priv, sync_pending, dacc_valid, dacc_addr, dacc_zone} = '0;
      {dacc_store_permit, dacc_user_attr, raise, fail, fill_valid, fill_idx, look_idx} = '0;
      dacc_op = exc_pkg::OP_LOAD;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rchk(8'h00, 32'h0);
      rchk(8'h18, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      `CHK(er, 1'b1, "unmapped error")
      apb(1'b1, 8'h14, 32'hABCD_0000);
      $display("reset and map test done");
      @(posedge pclk);
      raise <= 1'b1;
      repeat (4) @(posedge pclk);
      retire(32'h100, 0, 0, 0, 0, exc_pkg::OP_LOAD, 0, 1, 0, 0);
      `CHK(got_r, 1'b0, "critical while disabled")
      @(posedge pclk);
      sync_pending <= 1'b1;
      apb(1'b1, 8'h00, 32'h0002_D200);
      @(posedge pclk);
      sync_pending <= 1'b0;
      #1;
      `CHK(redirect, 1'b0, "critical while sync pending")
      @(posedge pclk);
      raise <= 1'b0;
      #1;
      `CHK(redirect, 1'b1, "critical taken")
      `CHK(redirect_pc, 32'hABCD_0100, "critical vector")
      rchk(8'h0C, 32'h104);
      rchk(8'h10, 32'h0002_D200);
      rchk(8'h00, 32'h0000_1000);
      retire(32'h5000, 0, 1, 0, 0, exc_pkg::OP_LOAD, 0, 1, 0, 0);
      `CHK(got_pc, 32'h104, "critical return")
      rchk(8'h00, 32'h0002_D200);
      $display("critical test done");
      apb(1'b1, 8'h00, 32'h0);
      retire(32'h200, 1, 0, 0, 0, exc_pkg::OP_LOAD, 0, 1, 0, 0);
      `CHK(got_r, 1'b0, "disabled machine check")
      rchk(8'h18, 32'h8000_0000);
      apb(1'b1, 8'h00, 32'h0000_1000);
      retire(32'h204, 0, 0, 0, 0, exc_pkg::OP_LOAD, 0, 1, 0, 0);
      `CHK(got_r, 1'b0, "old flag fired")
      apb(1'b1, 8'h18, 32'h00C0_8000);
      retire(32'h208, 1, 0, 0, 0, exc_pkg::OP_LOAD, 0, 1, 0, 0);
      `CHK(got_pc, 32'hABCD_0200, "fetch check vector")
      rchk(8'h0C, 32'h208);
      rchk(8'h18, 32'h8000_0000);
      rchk(8'h00, 32'h0);
      apb(1'b1, 8'h00, 32'h0002_1000);
      retire(32'h300, 0, 0, 0, 1, exc_pkg::OP_LOAD, 3, 1, 0, 1);
      `CHK(got_pc, 32'hABCD_0200, "data check vector")
      rchk(8'h0C, 32'h304);
      rchk(8'h10, 32'h0002_1000);
      rchk(8'h00, 32'h0);
      $display("machine check test done");
      apb(1'b1, 8'h20, 32'h1);
      dsi(exc_pkg::OP_STORE, 1, 0, 0, 1, 0, 1, 32'h8080_0000);
      dsi(exc_pkg::OP_STORE, 3, 0, 0, 1, 0, 0, 32'h8000_0000);
      dsi(exc_pkg::OP_LOAD, 0, 1, 0, 1, 0, 1, 32'h8040_0000);
      dsi(exc_pkg::OP_FLUSH, 0, 1, 0, 1, 0, 1, 32'h8040_0000);
      dsi(exc_pkg::OP_TOUCH, 0, 1, 0, 1, 0, 0, 32'h8000_0000);
      dsi(exc_pkg::OP_ICOP, 0, 0, 0, 1, 0, 1, 32'h8040_0000);
      dsi(exc_pkg::OP_STORE, 3, 1, 1, 1, 0, 1, 32'h8080_8000);
      dsi(exc_pkg::OP_LZERO, 2, 0, 0, 0, 0, 0, 32'h8000_0000);
      dsi(exc_pkg::OP_LINV, 1, 0, 0, 0, 0, 1, 32'h8080_0000);
      dsi(exc_pkg::OP_CINV, 0, 0, 0, 0, 0, 1, 32'h8080_0000);
      dsi(exc_pkg::OP_STORE, 1, 0, 0, 1, 1, 0, 32'h8000_0000);
      $display("data storage test done");
      for (int k = 0; k < 2; k++) begin
         for (int w = 0; w < 8; w++) begin
            @(posedge pclk);
            fill_valid <= 1'b1; fill_idx <= 4'h3 + 4'(k * 2); fail <= (k == 1 && w == 4);
         end
         @(posedge pclk);
         fill_valid <= 1'b0; fail <= 1'b0; look_idx <= 4'h3 + 4'(k * 2);
         repeat (3) @(posedge pclk);
         `CHK(look_valid, k == 0, "line valid after fill")
      end
      $display("line fill test done");
      give_verdict;
   end
endmodule // critical_mcheck_dsi_handler_test
`default_nettype wire
